// ### stmbc_pkg.sv
/*
  Constants and types shared by the serial transmitter mode, self-test and
  read-pulse control block.
  Assumes a single 100 MHz system clock; every link-side pin is asynchronous
  to it and is resynchronised inside the block.
*/
// Summary of operation
// - optic off forces primary, secondary pairs low
// - mode low: bytes go through the 8b10b encoder
// - mode high: ten raw input bits bypass encoder
// - mode mid: primary/secondary become test bit clock
// - self-test, no enables: alternate D10.2 and D21.5
// - self-test with an enable: repeating check sequence
// - generator steps on loaded self-test bytes only; violation input restarts it
// - self-test enable sampled on write-clock rise
// - read pulse low sixty percent of byte
// - read pulse at byte rate, own widths
// - self-test: read pulse low once per loop
// - load now, or next edge if next-enable low
// - both enables high: send null fill K28.5 (bypass mode still sends the ten raw input bits)
// - violation input overrides data and generator
// - character select high encodes a control code
package stmbc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_MHZ = 100;
  // serial bit time from the internal bit-clock divider, in ns
  localparam int unsigned BIT_TIME_NS = 40;
  localparam int unsigned BIT_DIV_CYCLES = (BIT_TIME_NS * CLOCK_MHZ) / 1000;
  localparam int unsigned SYMBOL_BITS = 10;
  // read pulse low share: 154/256 of the measured byte period
  localparam logic [8:0] RP_LOW_NUM = 9'h09A;
  localparam int unsigned PERIOD_W = 12;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned FIFO_WIDTH = 12;

  // ----------------------------------------------------------------
  // characters and self-test generator
  // ----------------------------------------------------------------
  localparam logic [7:0] CHAR_D10_2 = 8'h4A;
  localparam logic [7:0] CHAR_D21_5 = 8'hB5;
  localparam logic [7:0] CHAR_K28_5 = 8'hBC;
  // raw symbol sent in bypass mode while the queue is empty
  localparam logic [9:0] BYPASS_IDLE = 10'h0FA;
  localparam logic [7:0] LFSR_SEED = 8'h01;
  localparam logic [7:0] LFSR_TAPS = 8'hB8;
  // state the register holds on the last byte of the 255-byte loop
  localparam logic [7:0] LFSR_LAST = 8'h02;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] BITCNT_RST = 4'h0;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 12'h00A;

  typedef enum logic [1:0] {
    STMBC_MODE_ENCODE,
    STMBC_MODE_BYPASS,
    STMBC_MODE_TEST,
    STMBC_MODE_RSVD
  } stmbc_mode_t;

  typedef enum logic [1:0] {
    STMBC_CLS_DATA,
    STMBC_CLS_CTRL,
    STMBC_CLS_NULL,
    STMBC_CLS_VIOL
  } stmbc_cls_t;

  // resynchronised pin group
  typedef struct packed {
    logic tclk;
    logic optic_off;
    logic bist_n;
    logic enn_n;
    logic ena_n;
    logic viol;
    logic kind;
    logic [1:0] mode;
    logic [7:0] data;
    logic wclk;
  } stmbc_pins_t;

endpackage

// ### stmbc_top.sv
/*
  Transmit-side control: byte slot selection, self-test generator, read
  pulse timing, symbol queue and serial output gating, plus the symbol FIFO.
  Assumes an outside 8b10b encoder answers the queue head combinationally
  on the same clock, and pads or board logic resolve the two-way pins.
*/
`timescale 1ns/1ns

module stmbc_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } stmbc_fifo_st_t;

  stmbc_fifo_st_t st_r;
  stmbc_fifo_st_t st_nxt;
  logic push;
  logic pop;

  // a pop in the same cycle frees a place, so a full queue still accepts
  assign in_ready = (st_r.count != (AW+1)'(DEPTH)) || out_ready;
  assign out_valid = st_r.count != '0;
  assign out_data = st_r.mem[st_r.rd];

  always_comb begin
    st_nxt = st_r;
    pop = out_valid && out_ready;
    push = in_valid && (st_r.count != (AW+1)'(DEPTH) || pop);
    if (push) begin
      st_nxt.mem[st_r.wr] = in_data;
      st_nxt.wr = (st_r.wr == AW'(DEPTH - 1)) ? '0 : st_r.wr + 1'b1;
    end
    if (pop) begin
      st_nxt.rd = (st_r.rd == AW'(DEPTH - 1)) ? '0 : st_r.rd + 1'b1;
    end
    st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // stmbc_fifo

module stmbc_top (
  input wire logic clock,
  input wire logic reset,
  input wire logic byte_write_clock,
  input wire logic [7:0] parallel_byte_in,
  input wire logic char_kind_select,
  input wire logic send_violation,
  input wire logic load_now_enable_n,
  input wire logic load_next_enable_n,
  input wire logic self_test_enable_n,
  input wire logic optic_tx_off,
  input wire logic [1:0] encoder_mode,
  output logic fifo_read_pulse_n,
  output logic slot_ready,
  output logic [1:0] enc_class,
  output logic [7:0] enc_byte,
  input wire logic [9:0] enc_code,
  input wire logic serial_out_primary_in,
  output logic serial_out_primary_p,
  output logic serial_out_primary_n,
  output logic serial_out_primary_oe_n,
  input wire logic serial_out_secondary_in,
  output logic serial_out_secondary_p,
  output logic serial_out_secondary_n,
  output logic serial_out_secondary_oe_n,
  output logic serial_out_loopback_p,
  output logic serial_out_loopback_n
);

  typedef struct packed {
    stmbc_pkg::stmbc_pins_t sync1;
    stmbc_pkg::stmbc_pins_t sync2;
    logic wclk_d;
    logic tclk_d;
    // secondary half of the test-clock pair, own two-flop chain
    logic tsec1;
    logic tsec2;
    logic enn_pend;
    logic alt;
    logic [7:0] lfsr;
    logic [stmbc_pkg::PERIOD_W-1:0] per_cnt;
    logic [stmbc_pkg::PERIOD_W-1:0] per;
    logic [stmbc_pkg::PERIOD_W-1:0] rp_cnt;
    logic rp_low;
    logic [9:0] shreg;
    logic [3:0] bitcnt;
    logic [7:0] divcnt;
    logic out_bit;
  } stmbc_st_t;

  stmbc_st_t st_r;
  stmbc_st_t st_nxt;

  stmbc_pkg::stmbc_pins_t pins;
  stmbc_pkg::stmbc_mode_t mode;
  logic strobe;
  logic load;
  logic bist;
  logic bist_last;
  logic rp_trigger;
  logic bit_en;
  logic tclk_lvl;
  logic [20:0] rp_prod;
  logic [stmbc_pkg::PERIOD_W-1:0] rp_len;
  logic q_valid;
  logic [11:0] q_data;
  logic h_valid;
  logic h_ready;
  logic [11:0] h_data;
  logic [9:0] symbol;

  // ----------------------------------------------------------------
  // pin capture: everything from the link side crosses two flops
  // ----------------------------------------------------------------
  // each half of the test-clock pair gets its own flops; joining them
  // first would let pair skew glitch straight into the chain
  assign pins.tclk = serial_out_primary_in;
  assign pins.optic_off = optic_tx_off;
  assign pins.bist_n = self_test_enable_n;
  assign pins.enn_n = load_next_enable_n;
  assign pins.ena_n = load_now_enable_n;
  assign pins.viol = send_violation;
  assign pins.kind = char_kind_select;
  assign pins.mode = encoder_mode;
  assign pins.data = parallel_byte_in;
  assign pins.wclk = byte_write_clock;

  assign mode = stmbc_pkg::stmbc_mode_t'(st_r.sync2.mode);
  // write-clock rise, seen after resynchronisation
  assign strobe = st_r.sync2.wclk & ~st_r.wclk_d;
  assign bist = ~st_r.sync2.bist_n;
  assign load = ~st_r.sync2.ena_n | st_r.enn_pend;
  assign bist_last = st_r.lfsr == stmbc_pkg::LFSR_LAST;

  // ----------------------------------------------------------------
  // byte slot content
  // ----------------------------------------------------------------
  always_comb begin
    q_data = {stmbc_pkg::STMBC_CLS_NULL, 2'h0, stmbc_pkg::CHAR_K28_5};
    rp_trigger = 1'b0;
    if (mode == stmbc_pkg::STMBC_MODE_BYPASS) begin
      q_data = {stmbc_pkg::STMBC_CLS_DATA, st_r.sync2.viol,
                st_r.sync2.data, st_r.sync2.kind};
      rp_trigger = load;
    end else if (st_r.sync2.viol) begin
      q_data = {stmbc_pkg::STMBC_CLS_VIOL, 10'h000};
      rp_trigger = ~bist & load;
    end else if (bist && !load) begin
      q_data = {stmbc_pkg::STMBC_CLS_DATA, 2'h0,
                st_r.alt ? stmbc_pkg::CHAR_D21_5
                         : stmbc_pkg::CHAR_D10_2};
    end else if (bist) begin
      q_data = {stmbc_pkg::STMBC_CLS_DATA, 2'h0, st_r.lfsr};
      rp_trigger = bist_last;
    end else if (load) begin
      q_data = {st_r.sync2.kind ? stmbc_pkg::STMBC_CLS_CTRL
                                : stmbc_pkg::STMBC_CLS_DATA,
                2'h0, st_r.sync2.data};
      rp_trigger = 1'b1;
    end
    // else the slot keeps the null fill default
  end

  assign q_valid = strobe;
  // queue head, or idle fill when nothing is waiting
  assign enc_class = h_valid ? h_data[11:10] : stmbc_pkg::STMBC_CLS_NULL;
  assign enc_byte = h_valid ? h_data[7:0] : stmbc_pkg::CHAR_K28_5;
  assign symbol = (mode == stmbc_pkg::STMBC_MODE_BYPASS) ?
                  (h_valid ? h_data[9:0] : stmbc_pkg::BYPASS_IDLE) :
                  enc_code;

  // ----------------------------------------------------------------
  // serial timing
  // ----------------------------------------------------------------
  // test mode takes the bit clock from the released primary and secondary pins; the
  // pair is recombined only after both halves are synchronised
  assign tclk_lvl = st_r.sync2.tclk & ~st_r.tsec2;
  assign bit_en = (mode == stmbc_pkg::STMBC_MODE_TEST) ?
                  (tclk_lvl & ~st_r.tclk_d) :
                  (st_r.divcnt == 8'(stmbc_pkg::BIT_DIV_CYCLES - 1));
  assign h_ready = bit_en && st_r.bitcnt == stmbc_pkg::BITCNT_RST;

  // low time follows the measured byte period, not the clock duty
  assign rp_prod = st_r.per * stmbc_pkg::RP_LOW_NUM;
  assign rp_len = (rp_prod[19:8] == '0) ? 12'h001 : rp_prod[19:8];

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = pins;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.wclk_d = st_r.sync2.wclk;
    st_nxt.tsec1 = serial_out_secondary_in;
    st_nxt.tsec2 = st_r.tsec1;
    st_nxt.tclk_d = tclk_lvl;
    // saturates, so a stalled write clock gives a long pulse, not a wrap
    st_nxt.per_cnt = (st_r.per_cnt == '1) ? st_r.per_cnt
                                          : st_r.per_cnt + 1'b1;
    st_nxt.divcnt = bit_en || mode == stmbc_pkg::STMBC_MODE_TEST ?
                    8'h00 : st_r.divcnt + 1'b1;

    if (strobe) begin
      st_nxt.enn_pend = ~st_r.sync2.enn_n;
      st_nxt.per = st_r.per_cnt;
      st_nxt.per_cnt = 12'h001;
      st_nxt.alt = ~st_r.alt;
      if (bist && st_r.sync2.viol) begin
        st_nxt.lfsr = stmbc_pkg::LFSR_SEED;
      end else if (bist && load) begin
        // steps only on loaded self-test bytes: no seeding needed, wraps every 255 of them
        st_nxt.lfsr = st_r.lfsr[0] ?
                      (st_r.lfsr >> 1) ^ stmbc_pkg::LFSR_TAPS :
                      st_r.lfsr >> 1;
      end
    end

    if (strobe && rp_trigger) begin
      st_nxt.rp_low = 1'b1;
      st_nxt.rp_cnt = rp_len;
    end else if (st_r.rp_low) begin
      st_nxt.rp_cnt = st_r.rp_cnt - 1'b1;
      if (st_r.rp_cnt <= 12'h001) begin
        st_nxt.rp_low = 1'b0;
      end
    end

    if (bit_en) begin
      if (st_r.bitcnt == stmbc_pkg::BITCNT_RST) begin
        st_nxt.shreg = symbol >> 1;
        st_nxt.out_bit = symbol[0];
        st_nxt.bitcnt = 4'(stmbc_pkg::SYMBOL_BITS - 1);
      end else begin
        st_nxt.shreg = st_r.shreg >> 1;
        st_nxt.out_bit = st_r.shreg[0];
        st_nxt.bitcnt = st_r.bitcnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r <= '0;
      st_r.lfsr <= stmbc_pkg::LFSR_SEED;
      st_r.per <= stmbc_pkg::PERIOD_RST;
      st_r.bitcnt <= stmbc_pkg::BITCNT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // symbol queue between the byte slot and the shifter
  // ----------------------------------------------------------------
  // a full queue drops the slot; slot_ready tells the host to slow down
  stmbc_fifo #(
    .WIDTH(stmbc_pkg::FIFO_WIDTH),
    .DEPTH(stmbc_pkg::FIFO_DEPTH)
  ) u_queue (
    .clock(clock),
    .reset(reset),
    .in_valid(q_valid),
    .in_ready(slot_ready),
    .in_data(q_data),
    .out_valid(h_valid),
    .out_ready(h_ready),
    .out_data(h_data)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign fifo_read_pulse_n = ~st_r.rp_low;
  assign serial_out_primary_oe_n = mode == stmbc_pkg::STMBC_MODE_TEST;
  assign serial_out_secondary_oe_n = mode == stmbc_pkg::STMBC_MODE_TEST;
  assign serial_out_primary_p = st_r.out_bit & ~st_r.sync2.optic_off;
  assign serial_out_primary_n = ~serial_out_primary_p;
  assign serial_out_secondary_p = st_r.out_bit & ~st_r.sync2.optic_off;
  assign serial_out_secondary_n = ~serial_out_secondary_p;
  assign serial_out_loopback_p = st_r.out_bit;
  assign serial_out_loopback_n = ~st_r.out_bit;

endmodule // stmbc_top

// ### stmbc_host_model.sv
/*
  Far-side stand-in: crystal byte clock and a simple encoder answer.
  Assumes it shares the system clock of stmbc_top.
*/
`timescale 1ns/1ns
module stmbc_host_model #(
  parameter int HALF = 20
) (
  input wire logic clock,
  input wire logic [1:0] enc_class,
  input wire logic [7:0] enc_byte,
  output logic byte_write_clock,
  output logic [9:0] enc_code
);
  // ------------------------------------------------------------
  // byte clock and encoder stand-in
  // ------------------------------------------------------------
  int cnt = 0;
  initial byte_write_clock = 1'b0;
  // a crystal time base runs free, also between user bytes
  always @(posedge clock) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) byte_write_clock <= #1 ~byte_write_clock;
  end
  // not a real line code: distinct per byte, always a rise and a fall
  assign enc_code = {1'b0, ~enc_byte ^ {6'h00, enc_class}, 1'b1};
endmodule // stmbc_host_model

// ### stmbc_sva.sv
/*
  Checker for stmbc_top: pair gating, pin direction and read pulse.
  Bound to stmbc_top at the foot; watches its ports only.
*/
`timescale 1ns/1ns
module stmbc_sva (
  input wire logic clock,
  input wire logic reset,
  input wire logic load_now_enable_n,
  input wire logic load_next_enable_n,
  input wire logic self_test_enable_n,
  input wire logic optic_tx_off,
  input wire logic [1:0] encoder_mode,
  input wire logic fifo_read_pulse_n,
  input wire logic serial_out_primary_p,
  input wire logic serial_out_primary_n,
  input wire logic serial_out_primary_oe_n,
  input wire logic serial_out_secondary_p,
  input wire logic serial_out_secondary_n,
  input wire logic serial_out_secondary_oe_n,
  input wire logic serial_out_loopback_p,
  input wire logic serial_out_loopback_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // idle self-test counter: an earlier pulse has ended by 80
  // ------------------------------------------------------------
  logic [7:0] quiet_r;
  logic [7:0] quiet_nxt;
  wire idle_bist = !self_test_enable_n && load_now_enable_n
    && load_next_enable_n;
  always_comb quiet_nxt = !idle_bist ? 8'h00 : quiet_r + 8'(quiet_r != 8'hFF);
  always_ff @(posedge clock or posedge reset)
    if (reset) quiet_r <= 8'h00;
    else quiet_r <= quiet_nxt;
  AST_OPTIC_GATE: assert property (
    optic_tx_off [*6] |-> !serial_out_primary_p && serial_out_primary_n
      && !serial_out_secondary_p && serial_out_secondary_n)
    else $error("gated pair not at zero");
  AST_LOOP_COMPL: assert property (
    serial_out_loopback_p != serial_out_loopback_n)
    else $error("loopback pair not complementary");
  AST_PRIM_COMPL: assert property (
    !serial_out_primary_oe_n |-> serial_out_primary_p != serial_out_primary_n)
    else $error("primary pair not complementary");
  AST_TEST_OE: assert property (
    (encoder_mode == 2'h2) [*6] |-> serial_out_primary_oe_n
      && serial_out_secondary_oe_n)
    else $error("pins still driven in test mode");
  AST_DRIVE_OE: assert property (
    (encoder_mode != 2'h2) [*6] |-> !serial_out_primary_oe_n
      && !serial_out_secondary_oe_n)
    else $error("pins released outside test mode");
  AST_RP_BOUND: assert property (
    $fell(fifo_read_pulse_n) |-> ##[1:999] fifo_read_pulse_n)
    else $error("read pulse stuck low");
  AST_BIST_QUIET: assert property (
    quiet_r >= 8'h50 |-> fifo_read_pulse_n)
    else $error("read pulse low in idle self-test");
  AST_LOOP_ALIVE: assert property (
    @(posedge clock) disable iff (reset || encoder_mode == 2'h2)
    $rose(serial_out_loopback_p) |-> ##[1:60] $fell(serial_out_loopback_p))
    else $error("loopback stream stopped");
  COV_OPTIC: cover property (optic_tx_off && $rose(serial_out_loopback_p));
  COV_TEST: cover property (serial_out_primary_oe_n);
  COV_RP: cover property ($fell(fifo_read_pulse_n));
endmodule // stmbc_sva

bind stmbc_top stmbc_sva i_sva (.*);

// ### stmbc_top_tb.sv
/*
  Bench for stmbc_top; a host model gives byte clock and encoder answer.
  The bench resolves the two-way pins and plays the test-clock source.
*/
`timescale 1ns/1ns
module stmbc_top_tb;
  localparam int BYTE = 40;
  logic clock = 1'b0, reset = 1'b1, char_kind_select = 1'b0, tclk = 1'b0;
  logic send_violation = 1'b0, optic_tx_off = 1'b0, tclk_run = 1'b0;
  logic load_now_enable_n = 1'b1, load_next_enable_n = 1'b1;
  logic self_test_enable_n = 1'b1;
  logic [7:0] parallel_byte_in = 8'h00, enc_byte;
  logic [1:0] encoder_mode = 2'h0, enc_class;
  logic [9:0] enc_code;
  logic byte_write_clock, fifo_read_pulse_n, slot_ready;
  logic serial_out_primary_p, serial_out_primary_n, serial_out_primary_oe_n;
  logic serial_out_secondary_p, serial_out_secondary_n;
  logic serial_out_secondary_oe_n, serial_out_loopback_p, serial_out_loopback_n;
  wire serial_out_primary_in, serial_out_secondary_in;
  int failures = 0, cmp_count = 0;
  assign serial_out_primary_in =
    serial_out_primary_oe_n ? tclk : serial_out_primary_p;
  assign serial_out_secondary_in =
    serial_out_secondary_oe_n ? ~tclk : serial_out_secondary_p;
  always #5 clock = ~clock;
  always @(posedge clock) if (tclk_run) tclk <= #1 ~tclk;
  stmbc_top i_dut (.*);
  stmbc_host_model #(.HALF(BYTE / 2)) i_host (.*);
  // ------------------------------------------------------------
  // helpers and scenarios
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("failures %0d, comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic timeout();
    failures++;
    $display("mismatch at %0t: wait ran out", $time);
    complete_run();
  endtask
  task automatic until_lvl(input int w, input logic lvl, output int n);
    n = 0;
    while ((w == 0 ? fifo_read_pulse_n : slot_ready) !== lvl) begin
      tick(1);
      n++;
      if (n > 12000) timeout();
    end
  endtask
  // ends at a falling edge; lo + hi is one fall-to-fall period
  task automatic pulse(output int lo, output int hi);
    int n;
    until_lvl(0, 1'b1, n);
    until_lvl(0, 1'b0, n);
    until_lvl(0, 1'b1, lo);
    until_lvl(0, 1'b0, hi);
  endtask
  task automatic s_load_pulse();
    int lo, hi;
    load_now_enable_n = 1'b0;
    repeat (3) pulse(lo, hi);
    check(16'(lo), 16'((BYTE * stmbc_pkg::RP_LOW_NUM) >> 8));
    check(16'(lo + hi), 16'(BYTE));
    load_now_enable_n = 1'b1;
    load_next_enable_n = 1'b0;
    repeat (3) pulse(lo, hi);
    check(16'(lo + hi), 16'(BYTE));
    load_next_enable_n = 1'b1;
    tick(2 * BYTE);
    lo = 0;
    repeat (4 * BYTE) begin
      lo += int'(fifo_read_pulse_n !== 1'b1);
      tick(1);
    end
    check(16'(lo), 16'h0000);
  endtask
  task automatic s_classes();
    logic [12:0] tab [4];
    int n;
    // kind, violation, load_now_n, class, byte
    tab = '{13'h005A, 13'h113C, 13'h065A, 13'h0B5A};
    foreach (tab[i]) begin
      {char_kind_select, send_violation, load_now_enable_n} = tab[i][12:10];
      parallel_byte_in = tab[i][7:0];
      n = 0;
      while (enc_class !== tab[i][9:8]) begin
        tick(1);
        n++;
        if (n > 400) timeout();
      end
      if (tab[i][9:8] == 2'h2) check(16'(enc_byte), 16'(8'hBC));
      if (tab[i][9:8] < 2'h2) check(16'(enc_byte), 16'(tab[i][7:0]));
    end
    send_violation = 1'b0;
  endtask
  task automatic s_stream(input logic [1:0] m, input logic k,
      input logic [9:0] exp);
    logic [9:0] s;
    logic hit;
    encoder_mode = m;
    parallel_byte_in = 8'h3A;
    char_kind_select = k;
    load_now_enable_n = 1'b0;
    optic_tx_off = m[0];
    tick(10 * BYTE);
    hit = 1'b0;
    // every bit stands four clocks, so any fixed phase reads it
    for (int i = 0; i < 10; i++) begin
      s = {serial_out_loopback_p, s[9:1]};
      tick(4);
    end
    for (int r = 0; r < 10; r++)
      if (((exp >> r) | (exp << (10 - r))) === s) hit = 1'b1;
    check(16'(hit), 16'h0001);
    if (m[0]) check(16'({serial_out_primary_p, serial_out_primary_n,
      serial_out_secondary_p, serial_out_secondary_n}), 16'h0005);
    optic_tx_off = 1'b0;
    char_kind_select = 1'b0;
  endtask
  task automatic s_test();
    int n;
    encoder_mode = 2'h2;
    tick(10);
    check(16'({serial_out_primary_oe_n, serial_out_secondary_oe_n}),
      16'h0003);
    until_lvl(1, 1'b0, n);
    load_now_enable_n = 1'b1;
    tclk_run = 1'b1;
    until_lvl(1, 1'b1, n);
    tclk_run = 1'b0;
    encoder_mode = 2'h0;
    tick(10);
    check(16'({serial_out_primary_oe_n, serial_out_secondary_oe_n}),
      16'h0000);
  endtask
  task automatic s_bist();
    int lo, hi;
    logic [1:0] seen;
    self_test_enable_n = 1'b0;
    tick(100);
    seen = 2'h0;
    repeat (400) begin
      seen |= {enc_byte === stmbc_pkg::CHAR_D21_5,
        enc_byte === stmbc_pkg::CHAR_D10_2};
      tick(1);
    end
    check(16'(seen), 16'h0003);
    load_now_enable_n = 1'b0;
    pulse(lo, hi);
    check(16'(lo + hi), 16'(255 * BYTE));
    tick(5000);
    send_violation = 1'b1;
    tick(BYTE);
    send_violation = 1'b0;
    until_lvl(0, 1'b0, lo);
    check(16'(lo > 245 * BYTE && lo < 260 * BYTE), 16'h0001);
    self_test_enable_n = 1'b1;
  endtask
  initial begin
    tick(6);
    reset = 1'b0;
    tick(20);
    s_load_pulse();
    s_classes();
    s_stream(2'h0, 1'b0, {1'b0, ~8'h3A, 1'b1});
    s_stream(2'h3, 1'b0, {1'b0, ~8'h3A, 1'b1});
    s_stream(2'h1, 1'b1, {1'b0, 8'h3A, 1'b1});
    s_test();
    s_bist();
    complete_run();
  end
endmodule // stmbc_top_tb
